// file: aio_chk.sv
// port checker for the analog io router
// assumes binding onto aio_router, one clock domain
module aio_chk
import aio_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic run_request_in,
    input wire logic running_out,
    input wire logic trip_alarm_out,
    input wire logic param_wr_en_out,
    input wire logic [8:0] param_wr_tag_out,
    input wire logic [15:0] trim_out,
    input wire logic trim_valid_out,
    input wire logic [DAC_W-1:0] aout1_code_out,
    input wire logic [DAC_W-1:0] aout2_code_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    // request low long enough to cross the synchroniser
    sequence s_run_off;
        !run_request_in [*5];
    endsequence
    // fast scan is far longer than eight cycles
    sequence s_trim_gap;
        !trim_valid_out [*8];
    endsequence
    a_run_drop: assert property (s_run_off |-> !running_out)
        else $error("running without request");
    a_trip_stop: assert property (
        $rose(trip_alarm_out) |-> !running_out)
        else $error("trip raised while running");
    a_trim_clamp: assert property (trim_valid_out |->
        $signed(trim_out) <= 20000 && $signed(trim_out) >= -20000)
        else $error("input two beyond its clamp");
    a_trim_spaced: assert property (
        trim_valid_out |=> s_trim_gap)
        else $error("input two updated too often");
    a_wr_nonzero: assert property (
        param_wr_en_out |-> param_wr_tag_out != 9'h0)
        else $error("write to disconnected tag");
    a_wr_range: assert property (
        param_wr_en_out |-> param_wr_tag_out <= TAG_MAX)
        else $error("write tag beyond range");
    a_dac_sat: assert property (
        aout1_code_out != 12'h800 && aout2_code_out != 12'h800)
        else $error("output code not saturated");
    a_rd_quiet: assert property (
        !(hsel_in && htrans_in[1] && !hwrite_in && hready_in)
        |=> hrdata_out == 32'h0)
        else $error("read data outside data phase");
endmodule

// file: aio_pkg.sv
// constants, field layouts and reset values of the analog io router
// assumes one 100 MHz clock and a word-wide ahb-lite register port
// Operation
// RQ1 - edits allowed only unlocked, applied on relock
// RQ2 - refuse edits running, trip on unlocked start
// RQ3 - edits volatile until explicit save command
// RQ4 - five inputs, input two fixed, clamps 200%
// RQ5 - input two fast period, others slow period
// RQ6 - signed calibration ratio then upper clamp
// RQ7 - lower clamp, configurable inputs allow 300%
// RQ8 - configurable inputs write selected tag 0..499
// RQ9 - default destinations 100, 5, 48, 301
// RQ10 - destination must be writable, zero disconnects
// RQ11 - outputs reach 10 V at full-scale scaler
// RQ12 - rectify option makes negatives positive
// RQ13 - signed offset shifts each output
// RQ14 - outputs read source tag, defaults 62, 63
// RQ15 - values are scaled integers, 10000 is 100%
// RQ16 - parameters addressed by unique tag number
// RQ17 - calibrate then clamp, once per period
// RQ18 - scale, offset, rectify, saturate outputs
package aio_pkg;
    localparam int CLK_MHZ = 100; // clock rate in MHz
    localparam int FAST_PERIOD_US = 3330; // input two scan time
    localparam int SLOW_PERIOD_US = 7000; // other inputs scan time
    localparam int FAST_CYCLES = FAST_PERIOD_US * CLK_MHZ;
    localparam int SLOW_CYCLES = SLOW_PERIOD_US * CLK_MHZ;
    localparam int CNT_W = 20; // wide enough for both periods
    localparam logic [15:0] PCT_ONE = 16'h2710; // 100.00% see RQ15
    localparam logic [15:0] LIM_300 = 16'h7530; // 300.00% or 3.0000
    localparam logic [15:0] LIM_200 = 16'h4e20; // 200.00%
    localparam logic [15:0] LIM_100 = 16'h2710; // 100.00% offset limit
    localparam logic [8:0] TAG_MAX = 9'h1f3; // highest tag, 499
    localparam logic [15:0] DAC_FULL = 16'h07ff; // code for 10 V
    localparam int DAC_W = 12; // output converter width
    localparam int NUM_IN = 5;
    localparam int FIXED_CH = 1; // zero based index of input two
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS = 8'h08;
    localparam logic [7:0] TRIM_OFS = 8'h0c;
    localparam logic [2:0] OUT_REGION = 3'h3; // 0x60..0x7f
    // control bits
    localparam int CTRL_UNLOCK = 0;
    localparam int CTRL_SAVE = 1;
    localparam int CTRL_RUN = 2;
    // sticky status bits
    localparam int ST_TRIP = 0; // unlocked start alarm
    localparam int ST_SAVED = 1; // save completed
    localparam int ST_REFUSED = 2; // locked or running edit
    localparam int ST_W = 3;
    // per channel field words
    localparam logic [1:0] F_CAL = 2'h0; // also output scaler
    localparam logic [1:0] F_MAX = 2'h1; // also rectify option
    localparam logic [1:0] F_MIN = 2'h2; // also output offset
    localparam logic [1:0] F_TAG = 2'h3;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_WR = 3'b001,
        SEQ_RD = 3'b010,
        SEQ_WT = 3'b011,
        SEQ_CAP = 3'b100
    } aio_seq_e;
    typedef struct packed {
        logic [4:0][15:0] cal; // calibration ratio
        logic [4:0][15:0] maxv; // upper clamp
        logic [4:0][15:0] minv; // lower clamp
        logic [4:0][8:0] dest; // destination tag
        logic [1:0][15:0] scl; // full_scale_scaler
        logic [1:0][15:0] off; // output offset
        logic [1:0] rect; // rectify_option
        logic [1:0][8:0] src; // source_selector
    } aio_cfg_s;
    localparam aio_cfg_s CFG_DEF = '{
        cal: {5{16'h2710}},
        maxv: {5{16'h2710}},
        minv: {5{16'hd8f0}},
        dest: {9'h12d, 9'h030, 9'h005, 9'h000, 9'h064}, // see RQ9
        scl: {2{16'h2710}},
        off: {2{16'h0000}},
        rect: 2'h0,
        src: {9'h03f, 9'h03e} // see RQ14
    };
endpackage

// file: aio_router.sv
// analog io router: input scaling and routing, output sourcing
// assumes a parameter store that answers one cycle after a read tag
module aio_router #(
    parameter int FAST_CNT = aio_pkg::FAST_CYCLES,
    parameter int SLOW_CNT = aio_pkg::SLOW_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [4:0][15:0] ain_sample_in,
    input wire logic run_request_in,
    input wire logic power_fail_in,
    output logic running_out,
    output logic trip_alarm_out,
    output logic irq_out,
    output logic param_wr_en_out,
    output logic [8:0] param_wr_tag_out,
    output logic [15:0] param_wr_data_out,
    output logic [8:0] param_rd_tag_out,
    input wire logic [15:0] param_rd_data_in,
    output logic [15:0] trim_out,
    output logic trim_valid_out,
    output logic [aio_pkg::DAC_W-1:0] aout1_code_out,
    output logic [aio_pkg::DAC_W-1:0] aout2_code_out
);
    import aio_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [4:0][15:0] ain_s1; // first synchroniser stage
        logic [4:0][15:0] ain_s2;
        logic run_s1;
        logic run_s2;
        logic run_d; // previous run request, for edge
        logic pf_s1;
        logic pf_s2;
        aio_cfg_s edit; // software visible copy
        aio_cfg_s act; // copy the datapath uses
        aio_cfg_s saved; // survives a power loss
        logic unlock;
        logic running;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic irq;
        logic [4:0][15:0] smp; // held samples
        logic [CNT_W-1:0] fast_cnt;
        logic [CNT_W-1:0] slow_cnt;
        aio_seq_e seq;
        logic [1:0] idx; // configurable input being written
        logic oidx; // output being refreshed
        logic wr_en;
        logic [8:0] wr_tag;
        logic [15:0] wr_data;
        logic [8:0] rd_tag;
        logic [1:0][DAC_W-1:0] aout;
        logic [15:0] trim;
        logic trim_vld;
        logic fast_hit; // fast sample taken last cycle
        logic ap_vld; // write data phase pending
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic hready;
    } aio_st_s;

    aio_st_s s_ff; // registered state
    aio_st_s nxt_s; // next state

    logic [4:0][15:0] in_res; // clamped input results
    logic [15:0] out_res; // scaled output before offset
    logic [2:0] wr_ch; // input served by write index
    logic [31:0] rd_word; // read mux result
    logic [ST_W-1:0] set_ev; // events this cycle
    logic [ST_W-1:0] clr_ev; // software clears this cycle
    logic fast_tick;
    logic slow_tick;
    logic start_edge;
    logic cfg_ok; // edits are accepted now
    logic wr_cyc; // register write data phase now
    logic [15:0] wv; // written halfword
    logic [2:0] wch; // written input channel
    logic wk; // written output index
    logic tag_ok; // written tag fits the store
    logic [15:0] clim; // clamp limit of the written input
    int off_code; // offset expressed in converter codes
    int vo; // output value under construction

    ////////////////////////////////////////////////////////////////////
    // datapath instances
    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++) begin : g_in
            // calibrate then clamp each held sample see RQ6
            aio_scale_clamp u_in (
                .a_in(s_ff.smp[g]),
                .mul_in(s_ff.act.cal[g]),
                .div_in(PCT_ONE),
                .lo_in(s_ff.act.minv[g]),
                .hi_in(s_ff.act.maxv[g]),
                .y_out(in_res[g])
            );
        end
    endgenerate

    // source value scaled so the scaler value gives 10 V see RQ11
    aio_scale_clamp u_out (
        .a_in(param_rd_data_in),
        .mul_in(DAC_FULL),
        .div_in(s_ff.act.scl[s_ff.oidx]),
        .lo_in(16'h8000),
        .hi_in(16'h7fff),
        .y_out(out_res)
    );

    ////////////////////////////////////////////////////////////////////
    // saturate a written value to a symmetric limit
    function automatic logic [15:0] sat(input logic [15:0] v,
                                        input logic [15:0] lim);
        if (signed'(v) > signed'(lim)) begin
            sat = lim;
        end else if (signed'(v) < -signed'(lim)) begin
            sat = 16'(-signed'(lim));
        end else begin
            sat = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register read mux, edited copy is what software sees
    always_comb begin
        rd_word = '0;
        wch = s_ff.ap_addr[6:4] - 3'h1;
        wk = s_ff.ap_addr[4];
        clim = (wch == 3'(FIXED_CH)) ? LIM_200 : LIM_300; // see RQ4
        // read uses the incoming address phase
        if (haddr_in[7:4] == 4'h0) begin
            unique case (haddr_in[7:0])
                CTRL_OFS: begin
                    rd_word[CTRL_UNLOCK] = s_ff.unlock;
                    rd_word[CTRL_RUN] = s_ff.running;
                end
                STAT_OFS: rd_word[ST_W-1:0] = s_ff.status;
                MASK_OFS: rd_word[ST_W-1:0] = s_ff.mask;
                TRIM_OFS: rd_word[15:0] = s_ff.trim;
                default: rd_word = '0; // unmapped reads zero
            endcase
        end else if (!haddr_in[7] && haddr_in[6:4] <= 3'h5) begin
            unique case (haddr_in[3:2])
                F_CAL: rd_word[15:0] = s_ff.edit.cal[haddr_in[6:4]-3'h1];
                F_MAX: rd_word[15:0] = s_ff.edit.maxv[haddr_in[6:4]-3'h1];
                F_MIN: rd_word[15:0] = s_ff.edit.minv[haddr_in[6:4]-3'h1];
                F_TAG: rd_word[8:0] = s_ff.edit.dest[haddr_in[6:4]-3'h1];
            endcase
        end else if (haddr_in[7:5] == OUT_REGION) begin
            unique case (haddr_in[3:2])
                F_CAL: rd_word[15:0] = s_ff.edit.scl[haddr_in[4]];
                F_MAX: rd_word[0] = s_ff.edit.rect[haddr_in[4]];
                F_MIN: rd_word[15:0] = s_ff.edit.off[haddr_in[4]];
                F_TAG: rd_word[8:0] = s_ff.edit.src[haddr_in[4]];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_s = s_ff;
        set_ev = '0;
        clr_ev = '0;
        off_code = 0;
        vo = 0;
        wv = hwdata_in[15:0];
        tag_ok = hwdata_in[31:9] == '0 && hwdata_in[8:0] <= TAG_MAX;
        // pins cross through two flip-flops
        nxt_s.ain_s1 = ain_sample_in;
        nxt_s.ain_s2 = s_ff.ain_s1;
        nxt_s.run_s1 = run_request_in;
        nxt_s.run_s2 = s_ff.run_s1;
        nxt_s.run_d = s_ff.run_s2;
        nxt_s.pf_s1 = power_fail_in;
        nxt_s.pf_s2 = s_ff.pf_s1;
        start_edge = s_ff.run_s2 && !s_ff.run_d;

        // run control and the unlocked start alarm
        set_ev[ST_TRIP] = start_edge && s_ff.unlock; // see RQ2
        nxt_s.running = s_ff.run_s2 &&
            (s_ff.running || (start_edge && !s_ff.unlock));
        cfg_ok = s_ff.unlock && !s_ff.running; // see RQ1 see RQ2

        // ahb address phase, reads answer without wait states
        nxt_s.hready = 1'b1;
        nxt_s.ap_vld = 1'b0;
        nxt_s.hrdata = '0;
        if (hsel_in && htrans_in[1] && hready_in) begin
            nxt_s.ap_vld = hwrite_in;
            nxt_s.ap_addr = haddr_in[7:0];
            if (!hwrite_in) begin
                nxt_s.hrdata = rd_word;
            end
        end

        // ahb write data phase
        wr_cyc = s_ff.ap_vld;
        wr_ch = (s_ff.idx == 2'h0) ? 3'h0 : {1'b0, s_ff.idx} + 3'h1;
        if (wr_cyc && s_ff.ap_addr == CTRL_OFS) begin
            // unlock changes are refused while running
            if (s_ff.running) begin
                set_ev[ST_REFUSED] = hwdata_in[CTRL_UNLOCK] != s_ff.unlock;
            end else begin
                nxt_s.unlock = hwdata_in[CTRL_UNLOCK];
                if (s_ff.unlock && !hwdata_in[CTRL_UNLOCK]) begin
                    nxt_s.act = s_ff.edit; // see RQ1
                end
            end
            if (hwdata_in[CTRL_SAVE]) begin
                nxt_s.saved = s_ff.act; // see RQ3
                set_ev[ST_SAVED] = 1'b1;
            end
        end else if (wr_cyc && s_ff.ap_addr == STAT_OFS) begin
            clr_ev = hwdata_in[ST_W-1:0];
        end else if (wr_cyc && s_ff.ap_addr == MASK_OFS) begin
            nxt_s.mask = hwdata_in[ST_W-1:0];
        end else if (wr_cyc && s_ff.ap_addr[7:4] != 4'h0 &&
                     (s_ff.ap_addr[7:5] == OUT_REGION ||
                      (!s_ff.ap_addr[7] && s_ff.ap_addr[6:4] <= 3'h5))) begin
            if (!cfg_ok) begin
                set_ev[ST_REFUSED] = 1'b1;
            end else if (s_ff.ap_addr[7:5] == OUT_REGION) begin
                unique case (s_ff.ap_addr[3:2])
                    F_CAL: nxt_s.edit.scl[wk] = sat(wv, LIM_300); // see RQ11
                    F_MAX: nxt_s.edit.rect[wk] = wv[0]; // see RQ12
                    F_MIN: nxt_s.edit.off[wk] = sat(wv, LIM_100); // see RQ13
                    F_TAG: if (tag_ok) begin // see RQ14
                        nxt_s.edit.src[wk] = hwdata_in[8:0];
                    end
                endcase
            end else begin
                unique case (s_ff.ap_addr[3:2])
                    F_CAL: nxt_s.edit.cal[wch] = sat(wv, LIM_300); // see RQ6
                    F_MAX: nxt_s.edit.maxv[wch] = sat(wv, clim); // see RQ4
                    F_MIN: nxt_s.edit.minv[wch] = sat(wv, clim); // see RQ7
                    F_TAG: if (tag_ok && wch != 3'(FIXED_CH)) begin // see RQ8
                        nxt_s.edit.dest[wch] = hwdata_in[8:0];
                    end
                endcase
            end
        end

        // power loss throws away anything not saved see RQ3
        if (s_ff.pf_s2) begin
            nxt_s.edit = s_ff.saved;
            nxt_s.act = s_ff.saved;
            nxt_s.unlock = 1'b0;
        end

        // sample period counters see RQ5
        fast_tick = s_ff.fast_cnt == CNT_W'(FAST_CNT - 1);
        slow_tick = s_ff.slow_cnt == CNT_W'(SLOW_CNT - 1);
        nxt_s.fast_cnt = fast_tick ? '0 : s_ff.fast_cnt + 1'b1;
        nxt_s.slow_cnt = slow_tick ? '0 : s_ff.slow_cnt + 1'b1;

        // input two runs with the current loop, fixed target see RQ4
        nxt_s.fast_hit = fast_tick;
        nxt_s.trim_vld = s_ff.fast_hit;
        if (fast_tick) begin
            nxt_s.smp[FIXED_CH] = s_ff.ain_s2[FIXED_CH];
        end
        if (s_ff.fast_hit) begin
            nxt_s.trim = in_res[FIXED_CH]; // see RQ17
        end

        // slow sequence: four writes, then two output reads
        nxt_s.wr_en = 1'b0;
        unique case (s_ff.seq)
            SEQ_IDLE: begin
                if (slow_tick) begin
                    for (int i = 0; i < NUM_IN; i++) begin
                        if (i != FIXED_CH) begin
                            nxt_s.smp[i] = s_ff.ain_s2[i];
                        end
                    end
                    nxt_s.idx = 2'h0;
                    nxt_s.seq = SEQ_WR;
                end
            end
            SEQ_WR: begin
                // tag zero means disconnected, no write see RQ10
                nxt_s.wr_en = s_ff.act.dest[wr_ch] != 9'h000 &&
                              s_ff.act.dest[wr_ch] <= TAG_MAX; // see RQ8
                nxt_s.wr_tag = s_ff.act.dest[wr_ch]; // see RQ16
                nxt_s.wr_data = in_res[wr_ch]; // see RQ17
                nxt_s.idx = s_ff.idx + 2'h1;
                if (s_ff.idx == 2'h3) begin
                    nxt_s.oidx = 1'b0;
                    nxt_s.seq = SEQ_RD;
                end
            end
            SEQ_RD: begin
                nxt_s.rd_tag = s_ff.act.src[s_ff.oidx]; // see RQ14
                nxt_s.seq = SEQ_WT;
            end
            SEQ_WT: begin
                nxt_s.seq = SEQ_CAP; // store answers during capture
            end
            SEQ_CAP: begin
                // scale, offset, rectify, saturate see RQ18
                off_code = int'(signed'(s_ff.act.off[s_ff.oidx])) *
                           int'(DAC_FULL) / int'(PCT_ONE); // see RQ13
                vo = int'(signed'(out_res)) + off_code;
                if (s_ff.act.rect[s_ff.oidx] && vo < 0) begin
                    vo = -vo; // see RQ12
                end
                if (vo > int'(DAC_FULL)) begin
                    vo = int'(DAC_FULL);
                end else if (vo < -int'(DAC_FULL)) begin
                    vo = -int'(DAC_FULL);
                end
                nxt_s.aout[s_ff.oidx] = DAC_W'(vo);
                nxt_s.oidx = 1'b1;
                nxt_s.seq = s_ff.oidx ? SEQ_IDLE : SEQ_RD;
            end
            default: nxt_s.seq = SEQ_IDLE; // unused codes recover
        endcase

        // sticky status, a new event beats a clear in the same cycle
        nxt_s.status = (s_ff.status & ~clr_ev) | set_ev;
        nxt_s.irq = |(nxt_s.status & nxt_s.mask);
    end

    ////////////////////////////////////////////////////////////////////
    // state register, defaults at reset see RQ9
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_ff <= '0;
            s_ff.edit <= CFG_DEF;
            s_ff.act <= CFG_DEF;
            s_ff.saved <= CFG_DEF;
            s_ff.hready <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign hrdata_out = s_ff.hrdata;
    assign hreadyout_out = s_ff.hready;
    assign hresp_out = 1'b0 & s_ff.hready; // always okay
    assign running_out = s_ff.running;
    assign trip_alarm_out = s_ff.status[ST_TRIP];
    assign irq_out = s_ff.irq;
    assign param_wr_en_out = s_ff.wr_en;
    assign param_wr_tag_out = s_ff.wr_tag;
    assign param_wr_data_out = s_ff.wr_data;
    assign param_rd_tag_out = s_ff.rd_tag;
    assign trim_out = s_ff.trim;
    assign trim_valid_out = s_ff.trim_vld;
    assign aout1_code_out = s_ff.aout[0];
    assign aout2_code_out = s_ff.aout[1];
endmodule

// file: aio_scale_clamp.sv
// multiply, divide and clamp one signed scaled value
// assumes purely combinational use from the same clock domain
module aio_scale_clamp (
    input wire logic [15:0] a_in,
    input wire logic [15:0] mul_in,
    input wire logic [15:0] div_in,
    input wire logic [15:0] lo_in,
    input wire logic [15:0] hi_in,
    output logic [15:0] y_out
);
    logic signed [31:0] prod; // full product, never overflows
    logic signed [31:0] quo; // rescaled value
    logic signed [31:0] lo; // sign extended limits
    logic signed [31:0] hi;

    // ratio first, limits second see RQ17
    always_comb begin
        prod = signed'(a_in) * signed'(mul_in);
        lo = 32'(signed'(lo_in));
        hi = 32'(signed'(hi_in));
        // zero divisor gives zero rather than an undefined result
        if (div_in == 16'h0000) begin
            quo = '0;
        end else begin
            quo = prod / 32'(signed'(div_in));
        end
        if (quo > hi) begin
            y_out = hi_in; // see RQ6
        end else if (quo < lo) begin
            y_out = lo_in; // see RQ7
        end else begin
            y_out = quo[15:0];
        end
    end
endmodule

// file: aio_store.sv
// behavioural parameter store on the far side
// assumes reads answer one cycle after the tag
module aio_store (
    input wire logic clock_in,
    input wire logic wr_en_in,
    input wire logic [8:0] wr_tag_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [8:0] rd_tag_in,
    output logic [15:0] rd_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:511]; // one word per tag, all writable
    // preset the two default output sources
    initial begin
        foreach (mem[i]) mem[i] = 16'h0;
        mem[62] = 16'h2710;
        mem[63] = 16'hd8f0;
        rd_data_out = 16'h0;
    end
    // tag addressed write, one stage read to meet the capture state
    always @(posedge clock_in) begin
        if (wr_en_in) mem[wr_tag_in] <= wr_data_in;
        rd_data_out <= mem[rd_tag_in];
    end
endmodule

// file: aio_tb.sv
// self-checking bench for the analog io router
// assumes short scan counts and the store model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import aio_pkg::*;
    localparam int SLOW = 40; // shortened slow scan
    logic clock_in, reset_n_in, hsel, hwrite, ready, resp, run_req;
    logic pfail, running, trip, irq, wen, trim_v;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [4:0][15:0] ain;
    logic [8:0] wtag, rtag;
    logic [15:0] wdata, sdata, trim;
    logic [11:0] ao1, ao2;
    int failures, n_compared, cyc, i;
    aio_router #(.FAST_CNT(20), .SLOW_CNT(SLOW)) dut (.clock_in,
        .reset_n_in, .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(ready), .hrdata_out(hrdata),
        .hreadyout_out(ready), .hresp_out(resp), .ain_sample_in(ain),
        .run_request_in(run_req), .power_fail_in(pfail),
        .running_out(running), .trip_alarm_out(trip), .irq_out(irq),
        .param_wr_en_out(wen), .param_wr_tag_out(wtag),
        .param_wr_data_out(wdata), .param_rd_tag_out(rtag),
        .param_rd_data_in(sdata), .trim_out(trim),
        .trim_valid_out(trim_v), .aout1_code_out(ao1),
        .aout2_code_out(ao2));
    aio_store store (.clock_in, .wr_en_in(wen), .wr_tag_in(wtag),
        .wr_data_in(wdata), .rd_tag_in(rtag), .rd_data_out(sdata));
    ////////////////////////////////////////
    initial begin
        clock_in = 0;
        forever #5 clock_in = ~clock_in;
    end
    // hang guard, far above the few hundred cycles used
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single ahb-lite transfer, waits on hready
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clock_in); while (ready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_in); while (ready !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        {reset_n_in, hsel, hwrite, run_req, pfail} = 5'h0;
        {htrans, haddr, hwdata} = '0;
        ain = {16'h4e20, 16'hc568, 16'h04d2, 16'h7530, 16'h0bb8};
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rd(8'h1c, 32'h64);
        rd(8'h3c, 32'h5);
        rd(8'h4c, 32'h30);
        rd(8'h5c, 32'h12d);
        rd(8'h6c, 32'h3e);
        rd(8'h7c, 32'h3f);
        rd(8'h10, 32'h2710);
        rd(8'hf0, 32'h0);
        wr(8'h10, 32'h4e20);
        rd(8'h10, 32'h2710);
        rd(8'h04, 32'h4);
        wr(8'h08, 32'h4);
        @(posedge clock_in);
        chk({31'h0, irq}, 32'h1);
        wr(8'h04, 32'h4);
        repeat (2) @(posedge clock_in);
        chk({31'h0, irq}, 32'h0);
        $display("defaults and lock test done");
        // edits stay in the edited copy until relock
        wr(8'h00, 32'h1);
        wr(8'h10, 32'h4e20);
        wr(8'h1c, 32'hc8);
        wr(8'h1c, 32'h1f4);
        rd(8'h1c, 32'hc8);
        wr(8'h3c, 32'h0);
        wr(8'h68, 32'hd8f0);
        wr(8'h74, 32'h1);
        repeat (2 * SLOW + 24) @(posedge clock_in);
        chk({16'h0, store.mem[100]}, 32'hbb8);
        chk({16'h0, store.mem[5]}, 32'h4d2);
        chk({16'h0, store.mem[48]}, 32'hd8f0);
        chk({16'h0, store.mem[301]}, 32'h2710);
        chk({20'h0, ao1}, 32'h7ff);
        chk({20'h0, ao2}, 32'h801);
        wr(8'h00, 32'h0);
        ain[2] <= 16'h0100;
        repeat (2 * SLOW + 24) @(posedge clock_in);
        chk({16'h0, store.mem[200]}, 32'h1770);
        chk({16'h0, store.mem[5]}, 32'h4d2);
        chk({20'h0, ao1}, 32'h0);
        chk({20'h0, ao2}, 32'h7ff);
        for (i = 0; i < 60 && trim_v !== 1'b1; i++) @(posedge clock_in);
        chk({16'h0, trim}, 32'h2710);
        $display("routing and scaling test done");
        // start while unlocked trips, locked start runs
        wr(8'h00, 32'h1);
        run_req <= 1'b1;
        repeat (6) @(posedge clock_in);
        chk({30'h0, running, trip}, 32'h1);
        run_req <= 1'b0;
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h7);
        run_req <= 1'b1;
        repeat (6) @(posedge clock_in);
        chk({31'h0, running}, 32'h1);
        wr(8'h00, 32'h1);
        rd(8'h00, 32'h4);
        rd(8'h04, 32'h4);
        run_req <= 1'b0;
        $display("run interlock test done");
        // unsaved edits vanish on power loss, save is flagged
        pfail <= 1'b1;
        repeat (6) @(posedge clock_in);
        pfail <= 1'b0;
        repeat (4) @(posedge clock_in);
        rd(8'h1c, 32'h64);
        wr(8'h04, 32'h7);
        wr(8'h00, 32'h2);
        rd(8'h04, 32'h2);
        $display("power loss test done");
        tally_and_finish();
    end
endmodule
bind aio_router aio_chk chk (.clock_in, .reset_n_in, .hsel_in,
    .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .run_request_in,
    .running_out, .trip_alarm_out, .param_wr_en_out, .param_wr_tag_out,
    .trim_out, .trim_valid_out, .aout1_code_out, .aout2_code_out);
